// >>> include/iopd_pkg.sv
// Purpose: Constants shared by the port drive control block
// Assumes: APB3 slave, 32-bit data, one word per register
// Notes:   Drive codes follow the three-bit per-pin mode encoding
package iopd_pkg;
	localparam int PINS     = 8;
	localparam int AW       = 8;
	localparam int DW       = 32;

	// Port-form register byte offsets
	localparam logic [7:0] OFF_OUT_VALUE  = 8'h00;
	localparam logic [7:0] OFF_PIN_STATE  = 8'h04;
	localparam logic [7:0] OFF_DRV_LOW    = 8'h08;
	localparam logic [7:0] OFF_DRV_MID    = 8'h0c;
	localparam logic [7:0] OFF_DRV_HIGH   = 8'h10;
	localparam logic [7:0] OFF_BYPASS     = 8'h14;
	localparam logic [7:0] OFF_RISE_EN    = 8'h18;
	localparam logic [7:0] OFF_FALL_EN    = 8'h1c;
	localparam logic [7:0] OFF_INT_STATUS = 8'h20;
	// Pin-form registers: base plus four times the pin number
	localparam logic [2:0] PIN_FORM_SEL   = 3'h2;

	// Pin-form field positions
	localparam int PF_OUT   = 0;
	localparam int PF_STATE = 1;
	localparam int PF_DRV_L = 2;
	localparam int PF_DRV_H = 4;
	localparam int PF_BYP   = 5;
	localparam int PF_RISE  = 6;
	localparam int PF_FALL  = 7;

	// Reset values
	localparam logic [7:0] RST_OUT_VALUE = 8'h00;
	localparam logic [7:0] RST_DRV_BITS  = 8'h00;
	localparam logic [7:0] RST_BYPASS    = 8'h00;
	localparam logic [7:0] RST_INT_EN    = 8'h00;

	typedef enum logic [2:0] {
		DRV_HIZ_ANALOG  = 3'b000,
		DRV_HIZ_DIGITAL = 3'b001,
		DRV_RES_UP      = 3'b010,
		DRV_RES_DOWN    = 3'b011,
		DRV_OD_LOW      = 3'b100,
		DRV_OD_HIGH     = 3'b101,
		DRV_STRONG      = 3'b110,
		DRV_RES_BOTH    = 3'b111
	} iopd_drive_e;
endpackage

// >>> core/iopd_pin.sv
// Purpose: One pin: drive decode, input synchroniser, edge detector
// Assumes: pad_in is asynchronous to pclk
// Notes:   All outputs are registered
`timescale 1ns/1ps
module iopd_pin (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              pad_in,
	input  wire iopd_pkg::iopd_drive_e drive_mode_code,
	input  wire logic              out_bit,
	input  wire logic              bypass_bit,
	input  wire logic              periph_bit,
	input  wire logic              rise_en,
	input  wire logic              fall_en,
	output logic                   pad_out,
	output logic                   pad_oe,
	output logic                   pad_pu_en,
	output logic                   pad_pd_en,
	output logic                   pad_ie,
	output logic                   pin_state,
	output logic                   edge_event
);
	import iopd_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic drv_val;
	logic oe_n;
	logic pu_n;
	logic pd_n;
	logic ie_n;
	logic gated;
	logic ev_n;

	// Data source: port value or routed peripheral
	assign drv_val = bypass_bit ? periph_bit : out_bit;

	always_comb begin
		oe_n = 1'b0;
		pu_n = 1'b0;
		pd_n = 1'b0;
		ie_n = 1'b1;
		unique case (drive_mode_code)
			DRV_HIZ_ANALOG:  ie_n = 1'b0;
			DRV_HIZ_DIGITAL: ie_n = 1'b1;
			DRV_RES_UP: begin
				oe_n = ~drv_val;
				pu_n = drv_val;
			end
			DRV_RES_DOWN: begin
				oe_n = drv_val;
				pd_n = ~drv_val;
			end
			DRV_OD_LOW:  oe_n = ~drv_val;
			DRV_OD_HIGH: oe_n = drv_val;
			DRV_STRONG:  oe_n = 1'b1;
			DRV_RES_BOTH: begin
				pu_n = drv_val;
				pd_n = ~drv_val;
			end
		endcase
	end

	// Mode 0 supplies no digital input value
	assign gated = sync2_reg & pad_ie;
	assign ev_n  = (rise_en & gated & ~prev_reg) | (fall_en & ~gated & prev_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			prev_reg   <= 1'b0;
			pad_out    <= 1'b0;
			pad_oe     <= 1'b0;
			pad_pu_en  <= 1'b0;
			pad_pd_en  <= 1'b0;
			pad_ie     <= 1'b0;
			pin_state  <= 1'b0;
			edge_event <= 1'b0;
		end else if (ce) begin
			sync1_reg  <= pad_in;
			sync2_reg  <= sync1_reg;
			prev_reg   <= gated;
			pad_out    <= drv_val;
			pad_oe     <= oe_n;
			pad_pu_en  <= pu_n;
			pad_pd_en  <= pd_n;
			pad_ie     <= ie_n;
			pin_state  <= gated;
			edge_event <= ev_n;
		end
	end
endmodule

// >>> core/iopd_port.sv
// Purpose: Eight-pin port drive control with APB registers and port interrupt
// Assumes: APB3 master on pclk; pads resolved outside from the enables
// Notes:   Pin-form registers alias the port-form storage
//
// Summary of operation
// - Each pin has its own three-bit drive code choosing one of eight modes.
// - Pin drives port output bit, or routed peripheral signal when bypassed.
// - Code 000 is reset default; driver and input buffer both off.
// - Code 001 keeps driver off and input buffer on.
// - Code 010 resistive high/strong low; 011 strong high/resistive low.
// - Code 100 floats high, drives low; 101 drives high, floats low.
// - Code 110 drives strongly both high and low.
// - Code 111 resistive high for one, resistive low for zero.
// - Pin state read register is separate from output value register.
// - Port reset state is user settable and applied at reset.
// - Pins usable as input, output or both by processor, DMA, peripherals.
// - Pins interrupt on rising, falling or both edges.
// - Each port has one interrupt output combining its pins.
// - Port-form registers map bit n to pin n.
// - Per-pin register gathers eight bits, aliasing port-form storage.
// - Qualifying event sets pin status bit and requests an interrupt.
// - Each pin edge selection is independent: rise, fall, both, none.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module iopd_port #(
	parameter logic [7:0] RESET_OUT_VALUE = iopd_pkg::RST_OUT_VALUE,
	parameter logic [7:0] RESET_DRV_LOW   = iopd_pkg::RST_DRV_BITS,
	parameter logic [7:0] RESET_DRV_MID   = iopd_pkg::RST_DRV_BITS,
	parameter logic [7:0] RESET_DRV_HIGH  = iopd_pkg::RST_DRV_BITS
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [iopd_pkg::AW-1:0]   paddr,
	input  wire logic [iopd_pkg::DW-1:0]   pwdata,
	output logic      [iopd_pkg::DW-1:0]   prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [iopd_pkg::PINS-1:0] pad_in,
	output logic      [iopd_pkg::PINS-1:0] pad_out,
	output logic      [iopd_pkg::PINS-1:0] pad_oe,
	output logic      [iopd_pkg::PINS-1:0] pad_pu_en,
	output logic      [iopd_pkg::PINS-1:0] pad_pd_en,
	output logic      [iopd_pkg::PINS-1:0] pad_ie,
	input  wire logic [iopd_pkg::PINS-1:0] periph_out,
	output logic      [iopd_pkg::PINS-1:0] periph_in,
	output logic                           irq
);
	import iopd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [PINS-1:0] out_value_reg;
	logic [PINS-1:0] drv_low_reg;
	logic [PINS-1:0] drv_mid_reg;
	logic [PINS-1:0] drv_high_reg;
	logic [PINS-1:0] bypass_sel_reg;
	logic [PINS-1:0] rise_en_reg;
	logic [PINS-1:0] fall_en_reg;
	logic [PINS-1:0] int_status_reg;
	logic [PINS-1:0] out_value_next;
	logic [PINS-1:0] drv_low_next;
	logic [PINS-1:0] drv_mid_next;
	logic [PINS-1:0] drv_high_next;
	logic [PINS-1:0] bypass_sel_next;
	logic [PINS-1:0] rise_en_next;
	logic [PINS-1:0] fall_en_next;
	logic [PINS-1:0] int_status_next;
	logic [PINS-1:0] clr_mask_reg;
	logic [PINS-1:0] pin_state;
	logic [PINS-1:0] edge_event;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic       access;
	logic       done;
	logic       wr_done;
	logic       rd_capture;
	logic       is_pin_form;
	logic [2:0] pin_idx;
	logic [7:0] pin_mask;
	logic       hit_out;
	logic       hit_state;
	logic       hit_low;
	logic       hit_mid;
	logic       hit_high;
	logic       hit_byp;
	logic       hit_rise;
	logic       hit_fall;
	logic       hit_stat;
	logic       mapped;
	logic       wr_pin;
	logic       wr_out;
	logic       wr_low;
	logic       wr_mid;
	logic       wr_high;
	logic       wr_byp;
	logic       wr_rise;
	logic       wr_fall;
	logic       rd_stat;
	logic [7:0] pin_word;
	logic [7:0] port_word;
	logic [DW-1:0] rd_word;

	// Two-cycle access: ready rises on the second access cycle
	assign access     = psel & penable;
	assign rd_capture = access & ~pready;
	assign done       = access & pready;
	assign wr_done    = done & pwrite;

	assign is_pin_form = (paddr[7:5] == PIN_FORM_SEL) & (paddr[1:0] == 2'h0);
	assign pin_idx     = paddr[4:2];
	assign pin_mask    = 8'h01 << pin_idx;
	assign hit_out     = paddr == OFF_OUT_VALUE;
	assign hit_state   = paddr == OFF_PIN_STATE;
	assign hit_low     = paddr == OFF_DRV_LOW;
	assign hit_mid     = paddr == OFF_DRV_MID;
	assign hit_high    = paddr == OFF_DRV_HIGH;
	assign hit_byp     = paddr == OFF_BYPASS;
	assign hit_rise    = paddr == OFF_RISE_EN;
	assign hit_fall    = paddr == OFF_FALL_EN;
	assign hit_stat    = paddr == OFF_INT_STATUS;
	assign mapped      = hit_out | hit_state | hit_low | hit_mid | hit_high | hit_byp |
	                     hit_rise | hit_fall | hit_stat | is_pin_form;
	assign wr_pin      = wr_done & is_pin_form;

	// Port-form write strobes, one per writable register, and the status read strobe
	assign wr_out      = wr_done & hit_out;
	assign wr_low      = wr_done & hit_low;
	assign wr_mid      = wr_done & hit_mid;
	assign wr_high     = wr_done & hit_high;
	assign wr_byp      = wr_done & hit_byp;
	assign wr_rise     = wr_done & hit_rise;
	assign wr_fall     = wr_done & hit_fall;
	assign rd_stat     = done & ~pwrite & hit_stat;

	// Merge of one pin-form bit into a port-form register
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] msk, input logic b);
		merge = (old & ~msk) | (b ? msk : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next values: port form writes whole byte, pin form writes one bit
	assign out_value_next  = wr_out ? pwdata[7:0] :
	                         wr_pin ? merge(out_value_reg, pin_mask, pwdata[PF_OUT]) :
	                         out_value_reg;
	assign drv_low_next    = wr_low ? pwdata[7:0] :
	                         wr_pin ? merge(drv_low_reg, pin_mask, pwdata[PF_DRV_L]) :
	                         drv_low_reg;
	assign drv_mid_next    = wr_mid ? pwdata[7:0] :
	                         wr_pin ? merge(drv_mid_reg, pin_mask, pwdata[PF_DRV_L+1]) :
	                         drv_mid_reg;
	assign drv_high_next   = wr_high ? pwdata[7:0] :
	                         wr_pin ? merge(drv_high_reg, pin_mask, pwdata[PF_DRV_H]) :
	                         drv_high_reg;
	assign bypass_sel_next = wr_byp ? pwdata[7:0] :
	                         wr_pin ? merge(bypass_sel_reg, pin_mask, pwdata[PF_BYP]) :
	                         bypass_sel_reg;
	assign rise_en_next    = wr_rise ? pwdata[7:0] :
	                         wr_pin ? merge(rise_en_reg, pin_mask, pwdata[PF_RISE]) :
	                         rise_en_reg;
	assign fall_en_next    = wr_fall ? pwdata[7:0] :
	                         wr_pin ? merge(fall_en_reg, pin_mask, pwdata[PF_FALL]) :
	                         fall_en_reg;

	// Clear only what the read returned; a new event wins over the clear
	assign int_status_next = (int_status_reg & ~(rd_stat ? clr_mask_reg : 8'h00)) |
	                         edge_event;

	////////////////////////////////////////////////////////////////////////
	// Read path
	assign pin_word  = {fall_en_reg[pin_idx], rise_en_reg[pin_idx], bypass_sel_reg[pin_idx],
	                    drv_high_reg[pin_idx], drv_mid_reg[pin_idx], drv_low_reg[pin_idx],
	                    pin_state[pin_idx], out_value_reg[pin_idx]};

	always_comb begin
		port_word = 8'h00;
		unique case (1'b1)
			hit_out:   port_word = out_value_reg;
			hit_state: port_word = pin_state;
			hit_low:   port_word = drv_low_reg;
			hit_mid:   port_word = drv_mid_reg;
			hit_high:  port_word = drv_high_reg;
			hit_byp:   port_word = bypass_sel_reg;
			hit_rise:  port_word = rise_en_reg;
			hit_fall:  port_word = fall_en_reg;
			hit_stat:  port_word = int_status_reg;
			default:   port_word = 8'h00;
		endcase
	end

	assign rd_word = {24'h000000, is_pin_form ? pin_word : port_word};

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_value_reg  <= RESET_OUT_VALUE;
			drv_low_reg    <= RESET_DRV_LOW;
			drv_mid_reg    <= RESET_DRV_MID;
			drv_high_reg   <= RESET_DRV_HIGH;
			bypass_sel_reg <= RST_BYPASS;
			rise_en_reg    <= RST_INT_EN;
			fall_en_reg    <= RST_INT_EN;
			int_status_reg <= 8'h00;
		end else if (ce) begin
			out_value_reg  <= out_value_next;
			drv_low_reg    <= drv_low_next;
			drv_mid_reg    <= drv_mid_next;
			drv_high_reg   <= drv_high_next;
			bypass_sel_reg <= bypass_sel_next;
			rise_en_reg    <= rise_en_next;
			fall_en_reg    <= fall_en_next;
			int_status_reg <= int_status_next;
		end
	end

	// Bus response, interrupt output and peripheral input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata       <= 32'h00000000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			clr_mask_reg <= 8'h00;
			irq          <= 1'b0;
			periph_in    <= 8'h00;
		end else if (ce) begin
			pready       <= rd_capture;
			pslverr      <= rd_capture & ~mapped;
			irq          <= |int_status_next;
			periph_in    <= pin_state;
			if (rd_capture) begin
				prdata       <= (mapped & ~pwrite) ? rd_word : 32'h00000000;
				clr_mask_reg <= int_status_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins
	for (genvar i = 0; i < PINS; i++) begin : g_pin
		iopd_pin u_pin (
			.pclk            (pclk),
			.presetn         (presetn),
			.ce              (ce),
			.pad_in          (pad_in[i]),
			.drive_mode_code (iopd_drive_e'({drv_high_reg[i], drv_mid_reg[i], drv_low_reg[i]})),
			.out_bit         (out_value_reg[i]),
			.bypass_bit      (bypass_sel_reg[i]),
			.periph_bit      (periph_out[i]),
			.rise_en         (rise_en_reg[i]),
			.fall_en         (fall_en_reg[i]),
			.pad_out         (pad_out[i]),
			.pad_oe          (pad_oe[i]),
			.pad_pu_en       (pad_pu_en[i]),
			.pad_pd_en       (pad_pd_en[i]),
			.pad_ie          (pad_ie[i]),
			.pin_state       (pin_state[i]),
			.edge_event      (edge_event[i])
		);
	end
endmodule

// >>> tb/iopd_port_sva.sv
// Purpose: Port-level assertions for iopd_port
// Assumes: ce held high
// Notes:   Bound to iopd_port
`timescale 1ns/1ps
module iopd_port_sva (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      ce,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [iopd_pkg::AW-1:0]   paddr,
	input wire logic [iopd_pkg::DW-1:0]   prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic [iopd_pkg::PINS-1:0] pad_oe,
	input wire logic [iopd_pkg::PINS-1:0] pad_pu_en,
	input wire logic [iopd_pkg::PINS-1:0] pad_pd_en,
	input wire logic [iopd_pkg::PINS-1:0] pad_ie,
	input wire logic [iopd_pkg::PINS-1:0] periph_out,
	input wire logic                      irq
);
	import iopd_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire mapped = (paddr[1:0] == 2'h0) && ((paddr <= 8'h20) || (paddr[7:5] == 3'h2));
	wire st_rd  = pready && !pwrite && (paddr == OFF_INT_STATUS);
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_access;
		psel && penable && ce;
	endsequence
	AST_PREADY_SLOT: assert property (s_setup ##1 s_access ##1 s_access |-> pready)
		else $error("pready missing in second access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_DECODE: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_RDATA_WIDTH: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_DRIVE_EXCL: assert property (((pad_oe & (pad_pu_en | pad_pd_en)) | (pad_pu_en & pad_pd_en)) == 8'h0)
		else $error("conflicting pad drive enables");
	AST_ANALOG_OFF: assert property ((~pad_ie & (pad_oe | pad_pu_en | pad_pd_en)) == 8'h0)
		else $error("pad driven with input buffer off");
	AST_IRQ_HOLD: assert property (irq && !st_rd |=> irq)
		else $error("irq dropped without status read");
	AST_CFG_CAUSE: assert property (!$stable({pad_ie, pad_oe, pad_pu_en, pad_pd_en})
		|-> $past(pready && pwrite, 2) || ($past(periph_out) != $past(periph_out, 2)))
		else $error("pad config changed without cause");
endmodule
bind iopd_port iopd_port_sva i_iopd_port_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pad_oe(pad_oe), .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en), .pad_ie(pad_ie),
	.periph_out(periph_out), .irq(irq));

// >>> tb/iopd_pad_model.sv
// Purpose: External circuitry at the port pins
// Assumes: Device strong drive wins over external drive
// Notes:   Undriven pins wander each cycle
`timescale 1ns/1ps
module iopd_pad_model (
	input  wire logic                      pclk,
	input  wire logic [iopd_pkg::PINS-1:0] pad_out,
	input  wire logic [iopd_pkg::PINS-1:0] pad_oe,
	input  wire logic [iopd_pkg::PINS-1:0] pad_pu_en,
	input  wire logic [iopd_pkg::PINS-1:0] pad_pd_en,
	input  wire logic [iopd_pkg::PINS-1:0] ext_en,
	input  wire logic [iopd_pkg::PINS-1:0] ext_val,
	output logic      [iopd_pkg::PINS-1:0] pad_in
);
	import iopd_pkg::*;
	logic [PINS-1:0] float_reg = '0;
	always_ff @(posedge pclk) begin
		float_reg <= ~float_reg;
	end
	// External drive only where the device is not strong
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pu_en | (~pad_pd_en & float_reg)));
endmodule

// >>> tb/iopd_port_test.sv
// Purpose: Self-checking bench for iopd_port
// Assumes: APB master tasks, pad model on the pins
// Notes:   ce held high
`timescale 1ns/1ps
module iopd_port_test;
	import iopd_pkg::*;
	logic            pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, rerr;
	logic [AW-1:0]   paddr;
	logic [DW-1:0]   pwdata, prdata, rdat;
	logic [PINS-1:0] pad_in, pad_out, pad_oe, pad_pu_en, pad_pd_en, pad_ie, periph_out, periph_in;
	logic [PINS-1:0] ext_en, ext_val;
	int              error_cnt, n_tests, cyc;
	iopd_port i_iopd_port (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en),
		.pad_ie(pad_ie), .periph_out(periph_out), .periph_in(periph_in), .irq(irq));
	iopd_pad_model i_iopd_pad_model (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu_en(pad_pu_en),
		.pad_pd_en(pad_pd_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr_en;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Expected {oe, pu, pd, ie}
	function automatic logic [3:0] drv_exp(input logic [2:0] m, input logic d);
		case (m)
			3'h0: return 4'b0000;
			3'h1: return 4'b0001;
			3'h2: return d ? 4'b0101 : 4'b1001;
			3'h3: return d ? 4'b1001 : 4'b0011;
			3'h4: return d ? 4'b0001 : 4'b1001;
			3'h5: return d ? 4'b1001 : 4'b0001;
			3'h6: return 4'b1001;
			default: return d ? 4'b0101 : 4'b0011;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, periph_out, ext_val} = '0;
		ce     = 1'b1;
		ext_en = 8'hff;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 36; a += 4) rd(8'(a), 32'h0);
		chk(pad_ie, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 8; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr(8'h44, 8'(m * 4 + d));
				tick(2);
				chk({pad_oe[1], pad_pu_en[1], pad_pd_en[1], pad_ie[1]}, drv_exp(3'(m), d[0]));
				if (pad_oe[1] === 1'b1)
					chk(pad_out[1], 32'(d));
				rd(OFF_OUT_VALUE, 32'(d * 2));
				rd(8'h44, 32'(m * 4 + d + ((d == 1 && (m == 3 || m == 5 || m == 6)) ? 2 : 0)));
			end
		end
		$display("test modes done");
		wr(OFF_DRV_LOW, 8'h00);
		wr(OFF_DRV_MID, 8'hff);
		wr(OFF_DRV_HIGH, 8'hff);
		wr(OFF_OUT_VALUE, 8'ha5);
		tick(2);
		chk(pad_oe, 8'hff);
		chk(pad_out, 8'ha5);
		wr(OFF_PIN_STATE, 8'h00);
		rd(OFF_OUT_VALUE, 32'ha5);
		periph_out <= 8'h3c;
		wr(OFF_BYPASS, 8'h0f);
		tick(2);
		chk(pad_out, 8'hac);
		periph_out <= 8'hc3;
		tick(2);
		chk(pad_out, 8'ha3);
		wr(OFF_BYPASS, 8'h00);
		rd(8'h30, 32'h0);
		chk(rerr, 32'h1);
		rd(OFF_BYPASS, 32'h0);
		chk(rerr, 32'h0);
		$display("test port done");
		wr(OFF_DRV_LOW, 8'hff);
		wr(OFF_DRV_MID, 8'h00);
		wr(OFF_DRV_HIGH, 8'h00);
		wr(OFF_RISE_EN, 8'h05);
		wr(OFF_FALL_EN, 8'h06);
		tick(6);
		apb(1'b0, OFF_INT_STATUS, 32'h0);
		tick(2);
		chk(irq, 32'h0);
		ext_val <= 8'h0f;
		tick(8);
		chk(irq, 32'h1);
		chk(periph_in, 8'h0f);
		rd(OFF_PIN_STATE, 32'h0f);
		rd(OFF_INT_STATUS, 32'h05);
		tick(1);
		chk(irq, 32'h0);
		rd(OFF_INT_STATUS, 32'h0);
		ext_val <= 8'h00;
		tick(8);
		rd(OFF_INT_STATUS, 32'h06);
		$display("test interrupts done");
		print_verdict();
	end
endmodule
